// >>> verilog/hwmic_ctrl.sv
/*
  Interrupt aggregation and control outputs of a hardware monitor:
  status registers, masks, host and management interrupt lines,
  timed reset and intrusion-clear pulses, power hold, POST store.
  Assumes an APB master on REF_CLK and a monitoring loop outside
  that pulses limit events and marks the end of each loop.
*/
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module hwmic_ctrl #(
  parameter int PULSE_CYCLES = hwmic_pkg::PULSE_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [hwmic_pkg::LIMIT_N-1:0] LIMIT_EVT,
  input wire logic LOOP_DONE,
  output logic LOOP_RUN,
  input wire logic BOARD_TEMP_ALERT_N,
  input wire logic MGMT_INT_CHAIN_IN_N,
  input wire logic CHASSIS_INTR_I,
  output logic CHASSIS_INTR_O,
  output logic CHASSIS_INTR_OE,
  output logic HOST_INT,
  output logic MGMT_INT_OUT_N,
  output logic RESET_O,
  output logic RESET_OE,
  output logic POWER_HOLD_N
);
  import hwmic_pkg::*;

  // ==========================================================
  // State of the block
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] stat1;
    logic [7:0] stat2;
    logic [7:0] hmask1;
    logic [7:0] hmask2;
    logic [7:0] smask1;
    logic [7:0] smask2;
    logic [POST_DEPTH*8-1:0] ram;
    logic [5:0] wr_cnt;
    logic [6:0] addr_ptr;
    logic ack;
    logic [31:0] rdata;
    logic slverr;
  } hwmic_state_t;

  hwmic_state_t s_r;
  hwmic_state_t s_nxt;

  hwmic_pulse_if rst_if ();
  hwmic_pulse_if chs_if ();

  // ==========================================================
  // Pulse timers for the reset and intrusion-clear outputs
  hwmic_pulse_timer #(
    .CNT_W(PULSE_CNT_W),
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_rst_timer (
    .REF_CLK(REF_CLK),
    .RST_N(RST_N),
    .PULSE(rst_if.timer)
  );

  hwmic_pulse_timer #(
    .CNT_W(PULSE_CNT_W),
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_chs_timer (
    .REF_CLK(REF_CLK),
    .RST_N(RST_N),
    .PULSE(chs_if.timer)
  );

  // Commands held in the registers start the timers
  // Each timer ends its own bit, so a rewrite mid-pulse cannot stretch it
  assign rst_if.start = s_r.cfg[CFG_RST_PULSE];
  assign chs_if.start = s_r.hmask2[MASK2_CMD];

  // ==========================================================
  // Bus decode
  logic [5:0] idx;
  logic aligned;
  logic mapped;
  logic acc_end;
  logic wr_end;
  logic rd_end;

  assign idx = PADDR[7:2];
  assign aligned = (PADDR[1:0] == 2'b00);
  // Access completes at the edge where pready is seen high
  assign acc_end = PSEL & PENABLE & s_r.ack;
  assign wr_end = acc_end & PWRITE & ~s_r.slverr;
  assign rd_end = acc_end & ~PWRITE & ~s_r.slverr;

  // Status reads that complete now; only these clear status bits
  logic rd_stat1;
  logic rd_stat2;
  logic data_acc;
  assign rd_stat1 = rd_end & (idx == IDX_STAT1);
  assign rd_stat2 = rd_end & (idx == IDX_STAT2);
  // Either direction on the data port steps the read pointer
  assign data_acc = acc_end & ~s_r.slverr & (idx == IDX_DATA);

  // Register map check
  // Misaligned or unknown offsets answer with an error and no effect
  always_comb begin
    mapped = 1'b0;
    if (aligned) begin
      case (idx)
        IDX_POST_A, IDX_POST_B, IDX_ADDR, IDX_DATA: mapped = 1'b1;
        IDX_CFG, IDX_STAT1, IDX_STAT2: mapped = 1'b1;
        IDX_HMASK1, IDX_HMASK2, IDX_SMASK1, IDX_SMASK2: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Read value, snapshot in the first access cycle
  logic [7:0] rd_val;
  logic [7:0] ram_byte;

  assign ram_byte = s_r.ram[s_r.addr_ptr[4:0]*8 +: 8];

  always_comb begin
    rd_val = 8'h00;
    case (idx)
      IDX_ADDR: rd_val = {1'b0, s_r.addr_ptr};
      IDX_DATA: begin
        // Only the POST store answers in the indexed space
        if (s_r.addr_ptr < 7'(POST_DEPTH)) begin
          rd_val = ram_byte;
        end
      end
      IDX_CFG: rd_val = s_r.cfg;
      IDX_STAT1: rd_val = s_r.stat1;
      IDX_STAT2: rd_val = s_r.stat2;
      IDX_HMASK1: rd_val = s_r.hmask1;
      IDX_HMASK2: rd_val = s_r.hmask2;
      IDX_SMASK1: rd_val = s_r.smask1;
      IDX_SMASK2: rd_val = s_r.smask2;
      default: rd_val = 8'h00;
    endcase
  end

  // ==========================================================
  // Event sources
  logic loop_on;
  logic [7:0] set1;
  logic [7:0] set2;
  logic post_wr;
  logic post_ovf;

  // Monitoring loop halts while the interrupt-clear bit is high
  assign loop_on = s_r.cfg[CFG_START] & ~s_r.cfg[CFG_INT_CLR];

  assign post_wr = wr_end & ((idx == IDX_POST_A) | (idx == IDX_POST_B));
  assign post_ovf = post_wr & (s_r.wr_cnt == 6'(POST_DEPTH));

  // Limit events come as pulses from the loop, so they need no gate
  // External levels are sampled once per loop so a read stays clear
  always_comb begin
    set1 = 8'h00;
    set2 = 8'h00;
    if (loop_on) begin
      set1 = LIMIT_EVT[7:0];
      set2[2:0] = LIMIT_EVT[LIMIT_N-1:8];
      if (LOOP_DONE) begin
        set2[ST2_BOARD_TEMP] = ~BOARD_TEMP_ALERT_N;
        // Ignore our own clearing pulse on the intrusion wire
        set2[ST2_INTRUSION] = CHASSIS_INTR_I & ~chs_if.active;
        set2[ST2_CHAIN] = ~MGMT_INT_CHAIN_IN_N;
      end
    end
    set2[ST2_POST_OVF] = post_ovf;
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    // Bus handshake: one wait state so read data comes from flops
    if (PSEL & PENABLE & ~s_r.ack) begin
      s_nxt.ack = 1'b1;
      s_nxt.slverr = ~mapped;
      s_nxt.rdata = mapped ? {24'h000000, rd_val} : 32'h00000000;
    end else begin
      s_nxt.ack = 1'b0;
      s_nxt.slverr = 1'b0;
    end

    // Clear on read only the bits that were returned; sets win
    s_nxt.stat1 = s_r.stat1 | set1;
    s_nxt.stat2 = s_r.stat2 | set2;
    if (rd_stat1) begin
      s_nxt.stat1 = (s_r.stat1 & ~s_r.rdata[7:0]) | set1;
    end
    if (rd_stat2) begin
      s_nxt.stat2 = (s_r.stat2 & ~s_r.rdata[7:0]) | set2;
    end

    // POST port writes fill the store until it is full
    if (post_wr && s_r.wr_cnt < 6'(POST_DEPTH)) begin
      s_nxt.ram[s_r.wr_cnt[4:0]*8 +: 8] = PWDATA[7:0];
      s_nxt.wr_cnt = s_r.wr_cnt + 6'h01;
    end

    // Indexed port pair: pointer write, data read advances it
    if (wr_end && idx == IDX_ADDR) begin
      s_nxt.addr_ptr = PWDATA[6:0];
    end
    if (data_acc) begin
      s_nxt.addr_ptr = s_r.addr_ptr + 7'h01;
    end

    // Configuration; reset pulse bit only sets, and only if enabled
    if (wr_end && idx == IDX_CFG) begin
      s_nxt.cfg = PWDATA[7:0];
      s_nxt.cfg[CFG_RST_PULSE] = s_r.cfg[CFG_RST_PULSE]
        | (PWDATA[CFG_RST_PULSE] & s_r.smask2[MASK2_CMD]);
    end
    if (rst_if.done) begin
      s_nxt.cfg[CFG_RST_PULSE] = 1'b0;
    end

    // Masks; intrusion-clear command bit holds until the pulse ends
    if (wr_end && idx == IDX_HMASK1) begin
      s_nxt.hmask1 = PWDATA[7:0];
    end
    if (wr_end && idx == IDX_HMASK2) begin
      s_nxt.hmask2[6:0] = PWDATA[6:0];
      s_nxt.hmask2[MASK2_CMD] = s_r.hmask2[MASK2_CMD] | PWDATA[MASK2_CMD];
    end
    if (chs_if.done) begin
      s_nxt.hmask2[MASK2_CMD] = 1'b0;
    end
    if (wr_end && idx == IDX_SMASK1) begin
      s_nxt.smask1 = PWDATA[7:0];
    end
    if (wr_end && idx == IDX_SMASK2) begin
      s_nxt.smask2 = PWDATA[7:0];
    end
  end

  // ==========================================================
  // State register
  // The store is cleared in reset too, so a read never returns unknowns
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      s_r.cfg <= CFG_RESET;
      s_r.stat1 <= STAT_RESET;
      s_r.stat2 <= STAT_RESET;
      s_r.hmask1 <= MASK_RESET;
      s_r.hmask2 <= MASK_RESET;
      s_r.smask1 <= MASK_RESET;
      s_r.smask2 <= MASK_RESET;
      s_r.ram <= '0;
      s_r.wr_cnt <= 6'h00;
      s_r.addr_ptr <= ADDR_RESET;
      s_r.ack <= 1'b0;
      s_r.rdata <= 32'h00000000;
      s_r.slverr <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Interrupt lines
  logic [7:0] host_src1;
  logic [7:0] host_src2;
  logic [7:0] mgmt_src1;
  logic [7:0] mgmt_src2;
  logic host_pend;
  logic mgmt_pend;
  logic host_on;
  logic mgmt_on;

  // A zero mask bit lets that source through; bit 7 of the second
  // masks is a command, so it never gates a source
  assign host_src1 = s_r.stat1 & ~s_r.hmask1;
  assign host_src2 = s_r.stat2 & ~s_r.hmask2 & ST2_SRC_MASK;
  assign mgmt_src1 = s_r.stat1 & ~s_r.smask1;
  assign mgmt_src2 = s_r.stat2 & ~s_r.smask2 & ST2_SRC_MASK;

  // Lines follow the status flops, so a clearing read drops them next cycle
  assign host_pend = (|host_src1) | (|host_src2);
  assign mgmt_pend = (|mgmt_src1) | (|mgmt_src2);

  // Interrupt-clear forces both lines inactive, except where the chained input drives the management line
  assign host_on = host_pend & s_r.cfg[CFG_HOST_EN] & ~s_r.cfg[CFG_INT_CLR];
  assign mgmt_on = mgmt_pend & s_r.cfg[CFG_MGMT_EN] & ~s_r.cfg[CFG_INT_CLR];

  // Mode 1: active-high line, mode 0: active-low line
  assign HOST_INT = s_r.cfg[CFG_HOST_MODE] ? host_on : ~host_on;
  // Chained input passes straight through, whatever the masks say
  assign MGMT_INT_OUT_N = ~mgmt_on & MGMT_INT_CHAIN_IN_N;

  // ==========================================================
  // Control outputs
  assign LOOP_RUN = loop_on;
  assign POWER_HOLD_N = ~s_r.cfg[CFG_PWR_HOLD];
  // Open-drain pins only ever drive low
  // The reset pin lets go at once if its enable is cleared mid-pulse
  assign RESET_O = 1'b0;
  assign RESET_OE = rst_if.active & s_r.smask2[MASK2_CMD];
  assign CHASSIS_INTR_O = 1'b0;
  assign CHASSIS_INTR_OE = chs_if.active;

  // ==========================================================
  // APB answer
  // Error is qualified by ready so it never shows outside an answer
  assign PREADY = s_r.ack;
  assign PRDATA = s_r.rdata;
  assign PSLVERR = s_r.ack & s_r.slverr;

endmodule

// >>> verilog/hwmic_pkg.sv
/*
  Shared constants for the hardware-monitor interrupt controller:
  register indices, field positions, reset values and pulse timing.
  Assumes a 50 MHz reference clock and an APB bus with 32-bit words.
*/
package hwmic_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [5:0] IDX_POST_A = 6'h00;
  localparam logic [5:0] IDX_POST_B = 6'h04;
  localparam logic [5:0] IDX_ADDR = 6'h05;
  localparam logic [5:0] IDX_DATA = 6'h06;
  localparam logic [5:0] IDX_CFG = 6'h08;
  localparam logic [5:0] IDX_STAT1 = 6'h09;
  localparam logic [5:0] IDX_STAT2 = 6'h0A;
  localparam logic [5:0] IDX_HMASK1 = 6'h0B;
  localparam logic [5:0] IDX_HMASK2 = 6'h0C;
  localparam logic [5:0] IDX_SMASK1 = 6'h0D;
  localparam logic [5:0] IDX_SMASK2 = 6'h0E;

  // ==========================================================
  // Configuration register fields
  localparam int CFG_START = 0;
  localparam int CFG_MGMT_EN = 1;
  localparam int CFG_HOST_EN = 2;
  localparam int CFG_INT_CLR = 3;
  localparam int CFG_RST_PULSE = 4;
  localparam int CFG_HOST_MODE = 5;
  localparam int CFG_PWR_HOLD = 6;

  // Bit 7 of the second mask registers is a command, not a mask
  localparam int MASK2_CMD = 7;

  // ==========================================================
  // Second status register fields (first holds limit events 7..0)
  localparam int ST2_BOARD_TEMP = 3;
  localparam int ST2_INTRUSION = 4;
  localparam int ST2_POST_OVF = 5;
  localparam int ST2_CHAIN = 6;
  localparam logic [7:0] ST2_SRC_MASK = 8'h7F;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [6:0] ADDR_RESET = 7'h00;

  // ==========================================================
  // POST store and timing
  localparam int POST_DEPTH = 32;
  localparam int LIMIT_N = 11;
  localparam int PULSE_MIN_MS = 20;
  localparam int CLK_KHZ = 50000;
  localparam int PULSE_CYCLES = PULSE_MIN_MS * CLK_KHZ;
  localparam int PULSE_CNT_W = 20;

endpackage

// >>> verilog/hwmic_pulse_if.sv
/*
  Start/done handshake between the controller and a pulse timer.
  Assumes one controller and one timer per instance.
*/
`timescale 1ns/1ps
interface hwmic_pulse_if;
  logic start;
  logic done;
  logic active;
  modport ctrl (output start, input done, input active);
  modport timer (input start, output done, output active);
endinterface

// >>> verilog/hwmic_pulse_timer.sv
/*
  Timed low-pulse generator: once started, holds active for a fixed
  number of reference clock cycles and flags done in the last one.
  Assumes start stays high until done is seen.
*/
`timescale 1ns/1ps
module hwmic_pulse_timer #(
  parameter int CNT_W = hwmic_pkg::PULSE_CNT_W,
  parameter int PULSE_CYCLES = hwmic_pkg::PULSE_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  hwmic_pulse_if.timer PULSE
);
  import hwmic_pkg::*;

  // ==========================================================
  // State
  typedef enum logic [1:0] {
    HWMIC_IDLE = 2'b01,
    HWMIC_PULSE = 2'b10
  } hwmic_tstate_t;

  typedef struct packed {
    hwmic_tstate_t st;
    logic [CNT_W-1:0] cnt;
  } hwmic_timer_t;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(PULSE_CYCLES - 1);

  hwmic_timer_t s_r;
  hwmic_timer_t s_nxt;

  // Count exactly PULSE_CYCLES cycles, never fewer
  always_comb begin
    s_nxt = s_r;
    PULSE.done = 1'b0;
    case (s_r.st)
      HWMIC_IDLE: begin
        s_nxt.cnt = '0;
        if (PULSE.start) begin
          s_nxt.st = HWMIC_PULSE;
        end
      end
      HWMIC_PULSE: begin
        if (s_r.cnt == LAST) begin
          PULSE.done = 1'b1;
          s_nxt.st = HWMIC_IDLE;
          s_nxt.cnt = '0;
        end else begin
          s_nxt.cnt = s_r.cnt + 1'b1;
        end
      end
      default: begin
        s_nxt.st = HWMIC_IDLE;
        s_nxt.cnt = '0;
      end
    endcase
  end

  assign PULSE.active = (s_r.st == HWMIC_PULSE);

  // State register
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      s_r.st <= HWMIC_IDLE;
      s_r.cnt <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// >>> tb/hwmic_ctrl_properties.sv
/* Assertions on the interrupt controller top ports.
   Assumes PULSE_CYCLES matches the bound instance. */
`timescale 1ns/1ps
module hwmic_ctrl_properties import hwmic_pkg::*; #(
  parameter int PULSE_CYCLES = 8
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [LIMIT_N-1:0] LIMIT_EVT,
  input wire logic LOOP_DONE,
  input wire logic LOOP_RUN,
  input wire logic BOARD_TEMP_ALERT_N,
  input wire logic MGMT_INT_CHAIN_IN_N,
  input wire logic CHASSIS_INTR_I,
  input wire logic CHASSIS_INTR_O,
  input wire logic CHASSIS_INTR_OE,
  input wire logic HOST_INT,
  input wire logic MGMT_INT_OUT_N,
  input wire logic RESET_O,
  input wire logic RESET_OE,
  input wire logic POWER_HOLD_N
);
  // ==========================================================
  // Pull length counters; a plain repetition cannot carry the parameter
  logic [31:0] rcnt_r;
  logic [31:0] icnt_r;
  always_ff @(posedge REF_CLK) begin
    rcnt_r <= RESET_OE ? rcnt_r + 32'h1 : 32'h0;
    icnt_r <= CHASSIS_INTR_OE ? icnt_r + 32'h1 : 32'h0;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // ==========================================================
  // Write completion steps
  sequence s_done;
    PSEL && PENABLE && PREADY && PWRITE;
  endsequence
  sequence s_cfg;
    s_done ##0 (PADDR == {IDX_CFG, 2'b00});
  endsequence
  property p_chain;
    !MGMT_INT_CHAIN_IN_N |-> !MGMT_INT_OUT_N;
  endproperty
  a_chain: assert property (p_chain) else $error("chain input lost");
  property p_pwr;
    s_cfg |=> POWER_HOLD_N == !$past(PWDATA[6]);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power hold wrong");
  property p_run;
    s_cfg |=> LOOP_RUN == ($past(PWDATA[0]) && !$past(PWDATA[3]));
  endproperty
  a_run: assert property (p_run) else $error("loop run wrong");
  property p_host_off;
    s_cfg ##0 (!PWDATA[2] || PWDATA[3]) |=> HOST_INT == !$past(PWDATA[5]);
  endproperty
  a_host_off: assert property (p_host_off) else $error("host line active");
  property p_mgmt_off;
    s_cfg ##0 (!PWDATA[1] || PWDATA[3]) |=> MGMT_INT_OUT_N == MGMT_INT_CHAIN_IN_N;
  endproperty
  a_mgmt_off: assert property (p_mgmt_off) else $error("mgmt line active");
  property p_rlen;
    $fell(RESET_OE) |-> rcnt_r == PULSE_CYCLES;
  endproperty
  a_rlen: assert property (p_rlen) else $error("reset pulse length");
  property p_ilen;
    $fell(CHASSIS_INTR_OE) |-> icnt_r == PULSE_CYCLES;
  endproperty
  a_ilen: assert property (p_ilen) else $error("intrusion pulse length");
  property p_istart;
    s_done ##0 (PADDR == {IDX_HMASK2, 2'b00} && PWDATA[7] && !CHASSIS_INTR_OE)
      |-> ##2 CHASSIS_INTR_OE;
  endproperty
  a_istart: assert property (p_istart) else $error("intrusion pull late");
endmodule

bind hwmic_ctrl hwmic_ctrl_properties #(.PULSE_CYCLES(PULSE_CYCLES)) u_props (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .LIMIT_EVT(LIMIT_EVT), .LOOP_DONE(LOOP_DONE), .LOOP_RUN(LOOP_RUN),
  .BOARD_TEMP_ALERT_N(BOARD_TEMP_ALERT_N), .MGMT_INT_CHAIN_IN_N(MGMT_INT_CHAIN_IN_N),
  .CHASSIS_INTR_I(CHASSIS_INTR_I), .CHASSIS_INTR_O(CHASSIS_INTR_O),
  .CHASSIS_INTR_OE(CHASSIS_INTR_OE), .HOST_INT(HOST_INT), .MGMT_INT_OUT_N(MGMT_INT_OUT_N),
  .RESET_O(RESET_O), .RESET_OE(RESET_OE), .POWER_HOLD_N(POWER_HOLD_N));

// >>> tb/hwmic_host_model.sv
/* Board around the controller: intrusion latch, pulled-up wires.
   Assumes the bench drives the sensor and switch events. */
`timescale 1ns/1ps
module hwmic_host_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic intr_hit,
  input wire logic temp_hot,
  input wire logic chassis_o,
  input wire logic chassis_oe,
  input wire logic reset_o,
  input wire logic reset_oe,
  output logic chassis_wire,
  output logic reset_wire,
  output logic temp_alert_n
);
  logic latch_r;
  // ==========================================================
  // Intrusion latch holds until the device pulls the wire low
  always_ff @(posedge clk) begin
    if (!rst_n || chassis_oe) begin
      latch_r <= 1'b0;
    end else if (intr_hit) begin
      latch_r <= 1'b1;
    end
  end
  // Open-drain wires fall back to the intrusion latch or the reset pull-up when released
  assign chassis_wire = chassis_oe ? chassis_o : latch_r;
  assign reset_wire = reset_oe ? reset_o : 1'b1;
  assign temp_alert_n = !temp_hot;
endmodule

// >>> tb/hw_monitor_interrupt_control_bench.sv
/* Self-checking bench for the interrupt controller.
   Assumes the package constants and a short pulse parameter. */
`timescale 1ns/1ps
module hw_monitor_interrupt_control_bench;
  import hwmic_pkg::*;
  localparam int PC = 8;
  typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} hwmic_row_t;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic loop_done = 1'b0, chain_n = 1'b1, intr_hit = 1'b0, temp_hot = 1'b0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [10:0] limit_evt = 11'h000;
  logic pready, pslverr, loop_run, c_o, c_oe, host_int, mgmt_n, r_o, r_oe, pwr_n;
  logic c_wire, r_wire, alert_n;
  int fails = 0, checks = 0;
  hwmic_row_t rows[14];

  // ==========================================================
  // Clock, design and board
  always #10 clk = ~clk;
  hwmic_ctrl #(.PULSE_CYCLES(PC)) DUT (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LIMIT_EVT(limit_evt), .LOOP_DONE(loop_done),
    .LOOP_RUN(loop_run), .BOARD_TEMP_ALERT_N(alert_n), .MGMT_INT_CHAIN_IN_N(chain_n),
    .CHASSIS_INTR_I(c_wire), .CHASSIS_INTR_O(c_o), .CHASSIS_INTR_OE(c_oe),
    .HOST_INT(host_int), .MGMT_INT_OUT_N(mgmt_n), .RESET_O(r_o), .RESET_OE(r_oe),
    .POWER_HOLD_N(pwr_n));
  hwmic_host_model u_host (.clk(clk), .rst_n(rst_n), .intr_hit(intr_hit),
    .temp_hot(temp_hot), .chassis_o(c_o), .chassis_oe(c_oe), .reset_o(r_o),
    .reset_oe(r_oe), .chassis_wire(c_wire), .reset_wire(r_wire), .temp_alert_n(alert_n));

  // ==========================================================
  // Shared tasks
  function automatic logic [7:0] ad(input logic [5:0] i);
    return {i, 2'b00};
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  // Called just after an edge; ends with an idle edge so calls never collide
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n == 20) fails++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic evt(input logic [10:0] v);
    limit_evt <= v;
    @(posedge clk);
    limit_evt <= 11'h000;
    repeat (2) @(posedge clk);
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Cut a hang well past the expected run of some 500 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    test_done();
  end

  // ==========================================================
  // Main sequence
  initial begin
    rows = '{'{ad(IDX_CFG), 0, 0, 0, 0}, '{ad(IDX_STAT1), 0, 0, 0, 0},
      '{ad(IDX_STAT2), 0, 0, 0, 0}, '{ad(IDX_HMASK1), 0, 0, 0, 0},
      '{ad(IDX_HMASK2), 0, 0, 0, 0}, '{ad(IDX_SMASK1), 0, 0, 0, 0},
      '{ad(IDX_SMASK2), 0, 0, 0, 0}, '{ad(IDX_HMASK1), 1, 32'hFF, 0, 0},
      '{ad(IDX_HMASK1), 0, 0, 32'hFF, 0}, '{ad(IDX_SMASK1), 1, 32'hA5, 0, 0},
      '{ad(IDX_SMASK1), 0, 0, 32'hA5, 0}, '{8'hFC, 0, 0, 0, 1},
      '{ad(IDX_STAT1), 1, 32'hFF, 0, 0}, '{ad(IDX_STAT1), 0, 0, 0, 0}};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("host_int", host_int, 1);
    chk("power_hold_n", pwr_n, 1);
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w) chk("rdata", q, rows[i].x);
      chk("slverr", e, rows[i].e);
    end
    // Unmasked limit event on an enabled active-high line, then clear on read
    apb(ad(IDX_HMASK1), 1, 0);
    apb(ad(IDX_CFG), 1, 32'h25);
    evt(11'h004);
    chk("host_int", host_int, 1);
    apb(ad(IDX_STAT1), 0, 0);
    chk("stat1", q, 32'h04);
    chk("host_int", host_int, 0);
    apb(ad(IDX_STAT1), 0, 0);
    chk("stat1", q, 0);
    // Masked source is recorded but leaves the line idle
    apb(ad(IDX_HMASK1), 1, 32'h04);
    evt(11'h004);
    chk("host_int", host_int, 0);
    apb(ad(IDX_STAT1), 0, 0);
    chk("stat1", q, 32'h04);
    // External sources are sampled at the end of a loop
    temp_hot <= 1'b1;
    intr_hit <= 1'b1;
    chain_n <= 1'b0;
    @(posedge clk);
    intr_hit <= 1'b0;
    loop_done <= 1'b1; // one loop passes before the status read
    @(posedge clk);
    loop_done <= 1'b0;
    @(posedge clk);
    chk("mgmt_out_n", mgmt_n, 0);
    apb(ad(IDX_STAT2), 0, 0);
    chk("stat2", q, 32'h58);
    temp_hot <= 1'b0;
    chain_n <= 1'b1;
    // Intrusion clear pulse releases the latch and self-clears
    apb(ad(IDX_HMASK2), 1, 32'h80);
    repeat (PC + 4) @(posedge clk);
    chk("intr_wire", c_wire, 0);
    apb(ad(IDX_HMASK2), 0, 0);
    chk("hmask2", q, 0);
    // Reset pulse is refused until its enable is set
    apb(ad(IDX_CFG), 1, 32'h35);
    repeat (4) @(posedge clk);
    chk("reset_wire", r_wire, 1);
    apb(ad(IDX_SMASK2), 1, 32'h80);
    apb(ad(IDX_CFG), 1, 32'h35);
    @(posedge clk);
    chk("reset_wire", r_wire, 0);
    repeat (PC + 2) @(posedge clk);
    apb(ad(IDX_CFG), 0, 0);
    chk("cfg", q, 32'h25);
    // Management line and active-low host mode, then both cleared together
    apb(ad(IDX_SMASK1), 1, 32'hFE);
    apb(ad(IDX_CFG), 1, 32'h07);
    evt(11'h001);
    chk("mgmt_out_n", mgmt_n, 0);
    chk("host_int", host_int, 0);
    apb(ad(IDX_CFG), 1, 32'h0F);
    chk("mgmt_out_n", mgmt_n, 1);
    chk("host_int", host_int, 1);
    apb(ad(IDX_CFG), 1, 32'h25);
    apb(ad(IDX_STAT1), 0, 0);
    chk("stat1", q, 32'h01);
    // Interrupt clear halts the loop, so events are lost
    apb(ad(IDX_CFG), 1, 32'h6D);
    chk("power_hold_n", pwr_n, 0);
    evt(11'h001);
    apb(ad(IDX_CFG), 1, 32'h25);
    apb(ad(IDX_STAT1), 0, 0);
    chk("stat1", q, 0);
    // Fill the code store exactly, then one byte too many
    for (int i = 0; i < 32; i++) apb(i[0] ? ad(IDX_POST_B) : ad(IDX_POST_A), 1, 32'h40 + 32'(i));
    apb(ad(IDX_STAT2), 0, 0);
    chk("stat2", q, 0);
    apb(ad(IDX_POST_A), 1, 32'hEE);
    apb(ad(IDX_STAT2), 0, 0);
    chk("stat2", q, 32'h20);
    apb(ad(IDX_ADDR), 1, 0);
    for (int i = 0; i < 32; i++) begin
      apb(ad(IDX_DATA), 0, 0);
      chk("post", q, 32'h40 + 32'(i));
    end
    // Data port write steps the pointer; indices past the store read zero
    apb(ad(IDX_DATA), 1, 32'h99);
    apb(ad(IDX_ADDR), 0, 0);
    chk("addr_ptr", q, 32'h21);
    apb(ad(IDX_DATA), 0, 0);
    chk("post", q, 0);
    // Reset in mid-run returns registers and outputs to idle
    apb(ad(IDX_CFG), 1, 32'h65);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("power_hold_n", pwr_n, 1);
    chk("host_int", host_int, 1);
    apb(ad(IDX_CFG), 0, 0);
    chk("cfg", q, 0);
    apb(ad(IDX_ADDR), 0, 0);
    chk("addr_ptr", q, 0);
    test_done();
  end
endmodule
